//--- nvs_pkg.sv
/*
  Shared constants and types for the two-wire serial memory slave and its bus master.
  Assumes one core clock on both ends and a bench that joins the two through nvs_link_if.
*/
// What this block does
// - Answer only when select bits match straps
// - Write protect input high blocks all writes
// - Drive on falling SCL, sample on rising
// - Array of 32,768 bytes behind the link
// - Sixteen bit address, top bit ignored
// - Master sends top address bit as zero
// - Writes finish at once, no polling needed
// - Only reset is the power-on reset
// - Device is slave only, master clocks
// - Stop ends operations, device aborts on it
// - Master never stops while device sends data after an acknowledged read
// - Start begins every transaction
// - Start anywhere aborts, awaits new address
// - Master issues start before further operations
// - SDA steady while SCL high except conditions
// - Ninth clock: transmitter releases, receiver acknowledges
// - Missing acknowledge ends operation, readdressable again
// - Reads continue while master acknowledges
// - After acknowledge, next bit driven regardless
// - Address byte: bits 3-1 select, bit 0 read
// - Address increments per byte, wraps to zero
// - Protected writes: no acknowledge, no increment
// - Byte committed after eighth bit only
`default_nettype none
package nvs_pkg;
  // ****************************************
  // Array and address byte
  // ****************************************
  localparam int MEM_DEPTH = 32768;
  localparam int MEM_AW = 15;
  localparam int SA_TYPE_HI = 7;
  localparam int SA_TYPE_LO = 4;
  localparam int SA_SEL_HI = 3;
  localparam int SA_SEL_LO = 1;
  localparam int SA_RW_BIT = 0;
  // Arbitrary device type code
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_QTR_NS = 250;
  localparam int QTR_CYC = (T_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_RX = 3'b001, D_RXACK = 3'b010, D_TX = 3'b011, D_TXACK = 3'b100
  } nvs_dstate_t;
  typedef enum logic [1:0] {
    K_SADDR = 2'b00, K_AHI = 2'b01, K_ALO = 2'b10, K_DATA = 2'b11
  } nvs_kind_t;
  typedef enum logic [1:0] {
    OP_START = 2'b00, OP_STOP = 2'b01, OP_WRITE = 2'b10, OP_READ = 2'b11
  } nvs_op_t;
  typedef enum logic {
    H_IDLE = 1'b0, H_RUN = 1'b1
  } nvs_hstate_t;
endpackage
`default_nettype wire

//--- nvs_link_if.sv
/*
  Two-wire link between bus master and memory slave; resolves the open-drain SDA line.
  Assumes each end drives only low, with its enable low while it drives.
*/
`timescale 1ns/1ps
`default_nettype none
interface nvs_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // Pull-up wins unless some end pulls low
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface
`default_nettype wire

//--- nvs_dev.sv
/*
  Memory slave end: samples the link, decodes conditions, holds the byte array.
  Assumes SCL comes from the master and is far slower than CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_dev import nvs_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Link
  nvs_link_if.dev LINK,
  // Straps
  input wire logic [2:0] DEVICE_SELECT_STRAPS,
  input wire logic WRITE_PROTECT,
  // Status
  output logic SELECTED
);
  // ****************************************
  // Input synchronisers and filter
  // ****************************************
  // Bit 0 SCL, bit 1 SDA, bits 4:2 straps, bit 5 protect
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [5:0] prev_reg;
  logic [5:0] filt_reg;
  logic [5:0] filtd_reg;
  logic [5:0] pins;
  logic [5:0] filt_next;
  logic scl_hi;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic sda_in;

  assign pins = {WRITE_PROTECT, DEVICE_SELECT_STRAPS, LINK.sda, LINK.scl};

  // A change counts only once seen in two samples in a row
  always_comb begin
    filt_next = filt_reg;
    for (int i = 0; i < 6; i++) begin
      if (sync_reg[i] == prev_reg[i]) begin
        filt_next[i] = sync_reg[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_reg <= 6'h03;
      sync_reg <= 6'h03;
      prev_reg <= 6'h03;
      filt_reg <= 6'h03;
      filtd_reg <= 6'h03;
    end else if (CLK_EN) begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      filt_reg <= filt_next;
      filtd_reg <= filt_reg;
    end
  end

  // SCL is only ever observed, never driven
  assign scl_hi = filt_reg[0] & filtd_reg[0];
  assign start_ev = scl_hi & filtd_reg[1] & ~filt_reg[1];
  assign stop_ev = scl_hi & ~filtd_reg[1] & filt_reg[1];
  assign rise_ev = filt_reg[0] & ~filtd_reg[0];
  assign fall_ev = ~filt_reg[0] & filtd_reg[0];
  assign sda_in = filt_reg[1];

  // ****************************************
  // Byte array
  // ****************************************
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] rd_data;
  logic mem_we;

  // ****************************************
  // Protocol engine
  // ****************************************
  nvs_dstate_t state_reg;
  nvs_dstate_t state_next;
  nvs_kind_t kind_reg;
  nvs_kind_t kind_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [14:0] addr_reg;
  logic [14:0] addr_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic acked_reg;
  logic acked_next;
  logic sel_reg;
  logic sel_next;
  logic id_match;

  assign rd_data = mem[addr_reg];
  assign id_match = (sh_reg[SA_TYPE_HI:SA_TYPE_LO] == DEV_TYPE_ID) &&
                    (sh_reg[SA_SEL_HI:SA_SEL_LO] == filt_reg[4:2]);

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    oe_n_next = oe_n_reg;
    acked_next = acked_reg;
    mem_we = 1'b0;
    if (start_ev) begin
      // Abort anything and wait for a fresh address byte
      state_next = D_RX;
      kind_next = K_SADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (stop_ev) begin
      state_next = D_IDLE;
      oe_n_next = 1'b1;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
        end
        D_RX: begin
          if (rise_ev && cnt_reg < BITS_PER_BYTE) begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall_ev && cnt_reg == BITS_PER_BYTE) begin
            unique case (kind_reg)
              K_SADDR: begin
                if (id_match) begin
                  state_next = D_RXACK;
                  oe_n_next = 1'b0;
                end else begin
                  state_next = D_IDLE;
                end
              end
              K_AHI: begin
                // Top address bit is dropped
                addr_next = {sh_reg[6:0], addr_reg[7:0]};
                state_next = D_RXACK;
                oe_n_next = 1'b0;
              end
              K_ALO: begin
                addr_next = {addr_reg[14:8], sh_reg};
                state_next = D_RXACK;
                oe_n_next = 1'b0;
              end
              K_DATA: begin
                if (filt_reg[5]) begin
                  state_next = D_IDLE;
                end else begin
                  // Commit lands before the acknowledge clock starts
                  mem_we = 1'b1;
                  addr_next = addr_reg + 15'h0001;
                  state_next = D_RXACK;
                  oe_n_next = 1'b0;
                end
              end
            endcase
          end
        end
        D_RXACK: begin
          if (fall_ev) begin
            if (kind_reg == K_SADDR && sh_reg[SA_RW_BIT]) begin
              state_next = D_TX;
              sh_next = {rd_data[6:0], 1'b0};
              oe_n_next = rd_data[7];
              cnt_next = 4'h1;
            end else begin
              state_next = D_RX;
              cnt_next = 4'h0;
              oe_n_next = 1'b1;
              kind_next = (kind_reg == K_SADDR) ? K_AHI : (kind_reg == K_AHI) ? K_ALO : K_DATA;
            end
          end
        end
        D_TX: begin
          if (fall_ev) begin
            if (cnt_reg == BITS_PER_BYTE) begin
              oe_n_next = 1'b1;
              addr_next = addr_reg + 15'h0001;
              state_next = D_TXACK;
            end else begin
              oe_n_next = sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (rise_ev) begin
            acked_next = ~sda_in;
          end else if (fall_ev) begin
            if (acked_reg) begin
              // Master cannot stop us here: the bit goes out anyway
              state_next = D_TX;
              sh_next = {rd_data[6:0], 1'b0};
              oe_n_next = rd_data[7];
              cnt_next = 4'h1;
            end else begin
              state_next = D_IDLE;
            end
          end
        end
        default: begin
          state_next = D_IDLE;
          oe_n_next = 1'b1;
        end
      endcase
    end
    sel_next = (state_next != D_IDLE);
  end

  // Power-on reset is the only initialisation
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= D_IDLE;
      kind_reg <= K_SADDR;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      addr_reg <= ADDR_RST;
      oe_n_reg <= 1'b1;
      acked_reg <= 1'b0;
      sel_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      oe_n_reg <= oe_n_next;
      acked_reg <= acked_next;
      sel_reg <= sel_next;
    end
  end

  // Array holds no reset: contents survive
  always_ff @(posedge CORE_CLK) begin
    if (CLK_EN && mem_we) begin
      mem[addr_reg] <= sh_reg;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic zero_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign LINK.dev_sda_o = zero_reg;
  assign LINK.dev_sda_oe_n = oe_n_reg;
  assign SELECTED = sel_reg;
endmodule // nvs_dev
`default_nettype wire

//--- nvs_host.sv
/*
  Bus master end: runs start, stop and byte commands, makes SCL by a divider.
  Assumes a user that sends whole commands and drains read bytes through RD_*.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_host import nvs_pkg::*; (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Link
  nvs_link_if.host LINK,
  // Commands
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [1:0] CMD_OP,
  input wire logic [7:0] CMD_DATA,
  input wire logic CMD_LAST,
  // Read data
  output logic RD_VALID,
  input wire logic RD_READY,
  output logic [7:0] RD_DATA,
  // Status
  output logic WR_NACK,
  output logic BUSY
);
  // ****************************************
  // SDA synchroniser
  // ****************************************
  logic meta_reg;
  logic sync_reg;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else if (CLK_EN) begin
      meta_reg <= LINK.sda;
      sync_reg <= meta_reg;
    end
  end

  // ****************************************
  // Sequencer and read buffer
  // ****************************************
  nvs_hstate_t st_reg, st_next;
  nvs_op_t op_reg, op_next;
  logic [7:0] q_reg, q_next;
  logic [1:0] ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [8:0] tx_reg, tx_next;
  logic [8:0] rx_reg, rx_next;
  logic scl_reg, scl_next;
  logic oe_n_reg, oe_n_next;
  logic open_reg, open_next;
  logic more_reg, more_next;
  logic rdir_reg, rdir_next;
  logic [1:0] bidx_reg, bidx_next;
  logic nack_reg, nack_next;
  logic rdy_reg, rdy_next;
  logic busy_reg, busy_next;
  logic [7:0] s0_reg, s0_next, s1_reg, s1_next;
  logic v0_reg, v0_next, v1_reg, v1_next;
  logic tick;
  logic take;
  logic legal;
  logic done;
  logic push;
  logic [7:0] wdata;

  assign tick = (q_reg == QTR_LAST);
  assign take = CMD_VALID & rdy_reg & (st_reg == H_IDLE);

  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    q_next = q_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    scl_next = scl_reg;
    oe_n_next = oe_n_reg;
    open_next = open_reg;
    more_next = more_reg;
    rdir_next = rdir_reg;
    bidx_next = bidx_reg;
    nack_next = nack_reg;
    s0_next = s0_reg;
    s1_next = s1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    done = 1'b0;
    push = 1'b0;
    wdata = CMD_DATA;
    // Never stop or restart while the slave sends the byte after an acknowledged read
    unique case (nvs_op_t'(CMD_OP))
      OP_START: legal = ~more_reg;
      OP_STOP: legal = ~more_reg;
      OP_WRITE: legal = open_reg & ~more_reg;
      OP_READ: legal = open_reg;
    endcase
    if (bidx_reg == 2'h1 && !rdir_reg) begin
      wdata[7] = 1'b0;
    end
    if (take && legal) begin
      st_next = H_RUN;
      op_next = nvs_op_t'(CMD_OP);
      q_next = 8'h00;
      ph_next = 2'h0;
      bit_next = 4'h0;
      // Ninth bit released on writes, ack or no-ack on reads
      tx_next = (CMD_OP == OP_READ) ? {8'hff, CMD_LAST} : {wdata, 1'b1};
    end else if (st_reg == H_RUN) begin
      q_next = tick ? 8'h00 : q_reg + 8'h01;
      if (tick) begin
        ph_next = ph_reg + 2'h1;
        unique case (op_reg)
          OP_START: begin
            unique case (ph_reg)
              2'h0: oe_n_next = 1'b1;
              2'h1: scl_next = 1'b1;
              2'h2: oe_n_next = 1'b0;
              2'h3: begin
                scl_next = 1'b0;
                done = 1'b1;
              end
            endcase
          end
          OP_STOP: begin
            unique case (ph_reg)
              2'h0: oe_n_next = 1'b0;
              2'h1: scl_next = 1'b1;
              2'h2: begin
                oe_n_next = 1'b1;
                done = 1'b1;
              end
              2'h3: done = 1'b1;
            endcase
          end
          OP_WRITE, OP_READ: begin
            unique case (ph_reg)
              2'h0: oe_n_next = tx_reg[8];
              2'h1: scl_next = 1'b1;
              2'h2: rx_next = {rx_reg[7:0], sync_reg};
              2'h3: begin
                scl_next = 1'b0;
                tx_next = {tx_reg[7:0], 1'b1};
                bit_next = bit_reg + 4'h1;
                done = (bit_reg == BITS_PER_BYTE);
              end
            endcase
          end
        endcase
      end
    end
    if (done) begin
      st_next = H_IDLE;
      unique case (op_reg)
        OP_START: begin
          open_next = 1'b1;
          bidx_next = 2'h0;
        end
        OP_STOP: open_next = 1'b0;
        OP_WRITE, OP_READ: begin
          if (bidx_reg == 2'h0) begin
            // Own byte read back off the wire; tx has shifted out by now
            rdir_next = rx_reg[SA_RW_BIT + 1];
          end
          if (bidx_reg != 2'h3) begin
            bidx_next = bidx_reg + 2'h1;
          end
          nack_next = (op_reg == OP_WRITE) & rx_reg[0];
          more_next = (op_reg == OP_READ) & ~rx_reg[0];
          push = (op_reg == OP_READ);
        end
      endcase
    end
    // Head slot feeds the user; pop first, then fill
    if (v0_reg && RD_READY) begin
      s0_next = s1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    if (push) begin
      if (!v0_next) begin
        s0_next = rx_reg[8:1];
        v0_next = 1'b1;
      end else begin
        s1_next = rx_reg[8:1];
        v1_next = 1'b1;
      end
    end
    // Full buffer holds off the next command, so SCL simply waits
    rdy_next = (st_next == H_IDLE) & ~v1_next;
    busy_next = (st_next == H_RUN);
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= H_IDLE;
      op_reg <= OP_START;
      q_reg <= 8'h00;
      ph_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 9'h1ff;
      rx_reg <= 9'h000;
      scl_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      open_reg <= 1'b0;
      more_reg <= 1'b0;
      rdir_reg <= 1'b0;
      bidx_reg <= 2'h0;
      nack_reg <= 1'b0;
      rdy_reg <= 1'b0;
      busy_reg <= 1'b0;
      s0_reg <= 8'h00;
      s1_reg <= 8'h00;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else if (CLK_EN) begin
      st_reg <= st_next;
      op_reg <= op_next;
      q_reg <= q_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      scl_reg <= scl_next;
      oe_n_reg <= oe_n_next;
      open_reg <= open_next;
      more_reg <= more_next;
      rdir_reg <= rdir_next;
      bidx_reg <= bidx_next;
      nack_reg <= nack_next;
      rdy_reg <= rdy_next;
      busy_reg <= busy_next;
      s0_reg <= s0_next;
      s1_reg <= s1_next;
      v0_reg <= v0_next;
      v1_reg <= v1_next;
    end
  end

  assign LINK.scl = scl_reg;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.host_sda_oe_n = oe_n_reg;
  assign CMD_READY = rdy_reg;
  assign RD_VALID = v0_reg;
  assign RD_DATA = s0_reg;
  assign WR_NACK = nack_reg;
  assign BUSY = busy_reg;
endmodule // nvs_host
`default_nettype wire

//--- nvs_link_properties.sv
/*
  Link checker: timing of SCL and SDA between the two ends.
  Assumes it sits beside the link in the bench, on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_link_properties (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Link
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // ****
  // Conditions
  // ****
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  // ****
  // Checks
  // ****
  open_drain_a: assert property (!dev_sda_o && !host_sda_o)
    else $error("sda driven high");
  dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("slave moved sda with scl high");
  scl_steady_a: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("scl phase too short");
  sda_steady_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe_n))
    else $error("sda moved with scl high");
  stop_hold_a: assert property (stop_s |=> (scl && sda) [*8])
    else $error("bus not idle after stop");
  no_read_stop_a: assert property (stop_s |-> $past(dev_sda_oe_n))
    else $error("stop while slave drives");
  start_drive_a: assert property (start_s |-> $fell(host_sda_oe_n) && dev_sda_oe_n)
    else $error("start not made by master");
  start_clock_a: assert property (start_s |-> ##[1:60] $fell(scl))
    else $error("no clock after start");
  ack_slot_a: assert property ($fell(dev_sda_oe_n) |-> ##[1:120] $rose(scl))
    else $error("slave drive without clock");
  start_c: cover property (start_s);
  ack_c: cover property ($fell(dev_sda_oe_n));
  stop_c: cover property (stop_s);
endmodule // nvs_link_properties
`default_nettype wire

//--- nvs_test.sv
/*
  Bench: master and slave ends joined by the link, checker beside it.
  Assumes the command and read ports behave as handed over.
*/
`timescale 1ns/1ps
`default_nettype none
module nvs_test import nvs_pkg::*;;
  // ****
  // Stimulus and wiring
  // ****
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic rd_ready = 1'b0;
  logic [2:0] straps = 3'h0;
  logic wp = 1'b0;
  logic cmd_ready, rd_valid, wr_nack, busy, selected;
  logic [7:0] rd_data;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  typedef struct {logic [15:0] wa; logic [15:0] ra; logic [2:0] sel; logic [7:0] d;} nvs_row_t;
  nvs_row_t rows [2] = '{'{16'h8123, 16'h0123, 3'h6, 8'h5a}, '{16'h4000, 16'h4000, 3'h1, 8'ha5}};
  always #2.5 core_clk = ~core_clk;
  nvs_link_if nvs_link_if_inst ();
  nvs_host nvs_host_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .LINK(nvs_link_if_inst),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data), .WR_NACK(wr_nack), .BUSY(busy));
  nvs_dev nvs_dev_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1), .LINK(nvs_link_if_inst),
    .DEVICE_SELECT_STRAPS(straps), .WRITE_PROTECT(wp), .SELECTED(selected));
  nvs_link_properties nvs_link_properties_inst (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
    .scl(nvs_link_if_inst.scl), .host_sda_o(nvs_link_if_inst.host_sda_o),
    .host_sda_oe_n(nvs_link_if_inst.host_sda_oe_n), .dev_sda_o(nvs_link_if_inst.dev_sda_o),
    .dev_sda_oe_n(nvs_link_if_inst.dev_sda_oe_n), .sda(nvs_link_if_inst.sda));
  // ****
  // Tasks
  // ****
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until taken; bounded waits so a hang still reaches the timeout
  task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic last);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_last = last;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 4000);
    #1 cmd_valid = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check({7'h00, busy}, 8'h01);
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    #1;
  endtask
  task automatic wbyte(input logic [7:0] d, input logic [7:0] nack);
    cmd(OP_WRITE, d, 1'b0);
    check({7'h00, wr_nack}, nack);
  endtask
  task automatic setaddr(input logic [15:0] a);
    cmd(OP_START, 8'h00, 1'b0);
    wbyte({DEV_TYPE_ID, straps, 1'b0}, 8'h00);
    wbyte(a[15:8], 8'h00);
    wbyte(a[7:0], 8'h00);
  endtask
  task automatic rdstart();
    cmd(OP_START, 8'h00, 1'b0);
    wbyte({DEV_TYPE_ID, straps, 1'b1}, 8'h00);
  endtask
  task automatic pop(input logic [7:0] exp);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(rd_data, exp);
    rd_ready = 1'b1;
    @(posedge core_clk);
    #1 rd_ready = 1'b0;
  endtask
  // ****
  // Sequence
  // ****
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    foreach (rows[i]) begin
      straps = rows[i].sel;
      setaddr(rows[i].wa);
      wbyte(rows[i].d, 8'h00);
      cmd(OP_STOP, 8'h00, 1'b0);
      setaddr(rows[i].ra);
      rdstart();
      cmd(OP_READ, 8'h00, 1'b1);
      pop(rows[i].d);
      cmd(OP_STOP, 8'h00, 1'b0);
    end
    // Wrap at the top location, reads stall on a full buffer
    straps = 3'h3;
    setaddr(16'h7fff);
    wbyte(8'he1, 8'h00);
    wbyte(8'he2, 8'h00);
    wbyte(8'he3, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    setaddr(16'h7fff);
    rdstart();
    cmd(OP_READ, 8'h00, 1'b0);
    cmd(OP_READ, 8'h00, 1'b0);
    repeat (20) @(posedge core_clk);
    #1 check({5'h00, busy, rd_valid, cmd_ready}, 8'h02);
    pop(8'he1);
    pop(8'he2);
    check({7'h00, rd_valid}, 8'h00);
    cmd(OP_READ, 8'h00, 1'b1);
    pop(8'he3);
    // Slave sees the ninth fall a few cycles after the master
    repeat (8) @(posedge core_clk);
    #1 check({7'h00, selected}, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Protected write: refused, latch left at 0000
    wp = 1'b1;
    setaddr(16'h0000);
    wbyte(8'h77, 8'h01);
    check({7'h00, selected}, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    wp = 1'b0;
    rdstart();
    cmd(OP_READ, 8'h00, 1'b1);
    pop(8'he2);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Select bits that miss the straps
    straps = 3'h5;
    cmd(OP_START, 8'h00, 1'b0);
    wbyte({DEV_TYPE_ID, 3'h2, 1'b0}, 8'h01);
    check({7'h00, selected}, 8'h00);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Reset in mid-run clears the link and the latch
    cmd(OP_START, 8'h00, 1'b0);
    check({7'h00, selected}, 8'h01);
    sys_rst = 1'b1;
    repeat (12) @(posedge core_clk);
    check({5'h00, selected, nvs_link_if_inst.scl, nvs_link_if_inst.sda}, 8'h03);
    #1 sys_rst = 1'b0;
    rdstart();
    cmd(OP_READ, 8'h00, 1'b1);
    pop(8'he2);
    cmd(OP_STOP, 8'h00, 1'b0);
    conclude();
  end
endmodule // nvs_test
`default_nettype wire
